// ==== rtl/eil_map.vh ====
`ifndef EIL_MAP_VH
`define EIL_MAP_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define EIL_ADDR_W        4
`define EIL_ADDR_ISC      4'h0
`define EIL_ADDR_BFC      4'h1
`define EIL_ADDR_PIN      4'h2

// ----------------------------------------------------------------
// Status and control fields
// ----------------------------------------------------------------
`define EIL_BIT_MODE      0
`define EIL_BIT_MASK      1
`define EIL_BIT_ACK       2
`define EIL_BIT_PEND      3
`define EIL_BIT_BRKCLR    7
`define EIL_BIT_PINLVL    0

// ----------------------------------------------------------------
// Reset values and vector
// ----------------------------------------------------------------
`define EIL_RST_BIT       1'h0
`define EIL_SYNC_RST      1'h0
`define EIL_LATCH_SET     1'h1
`define EIL_LATCH_CLR     1'h0
`define EIL_RD_ZERO       8'h00
`define EIL_VEC_HI        16'hFFFA
`define EIL_VEC_LO        16'hFFFB

`endif

// ==== rtl/eil_sync.v ====
`timescale 1ns/10ps
`include "eil_map.vh"

// Two-stage synchroniser; it resets low so that a pin held low through
// reset is not mistaken for a new falling edge
module eil_sync (
  clk,
  rst_n,
  d_in,
  q_out
);
  input  wire clk;
  input  wire rst_n;
  input  wire d_in;
  output wire q_out;

  reg meta_r;
  reg sync_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= `EIL_SYNC_RST;
      sync_r <= `EIL_SYNC_RST;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule

// ==== rtl/eil_top.v ====
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "eil_map.vh"

// How it works
// - Falling edge sets latch; low level holds pending in level mode
// - Vector fetch acknowledge clears the latch
// - Writing one to ack bit clears latch
// - Reset clears latch and sensitivity bit
// - Edge-only after reset, level mode selectable
// - Edge mode: latch holds until ack
// - Level mode: needs ack and pin high
// - Level mode: pending while pin low
// - Mask bit hides request from priority logic
// - Edge after ack latches new request
// - Taken request uses vector FFFA/FFFB
// - Pending flag ignores mask bit
// - Break clear enable lets ack work
// - Without break enable, ack in break ignored
// - Pending flag read-only, shows latch or level hold
// - Ack bit write-only, reads zero
// - Mask bit read/write, reset clears
// - Sensitivity bit read/write, reset clears
module eil_top (
  clk,
  rst_n,
  irq_pin_n,
  vector_fetch,
  break_state,
  addr,
  wdata,
  wr_stb,
  rd_stb,
  rdata,
  irq_req,
  pending_flag,
  vector_addr_hi,
  vector_addr_lo
);
  input  wire                    clk;
  input  wire                    rst_n;
  input  wire                    irq_pin_n;
  input  wire                    vector_fetch;
  input  wire                    break_state;
  input  wire [`EIL_ADDR_W-1:0]  addr;
  input  wire [7:0]              wdata;
  input  wire                    wr_stb;
  input  wire                    rd_stb;
  output reg  [7:0]              rdata;
  output reg                     irq_req;
  output reg                     pending_flag;
  output reg  [15:0]             vector_addr_hi;
  output reg  [15:0]             vector_addr_lo;

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------------------------------
  wire pin_s;
  wire pin_low;
  wire fall_edge;
  reg  pin_d_r;

  eil_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  (irq_pin_n),
    .q_out (pin_s)
  );

  // Same reset level as the synchroniser: a pin held low through reset
  // must not show up as a falling edge once reset lets go
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_d_r <= `EIL_SYNC_RST;
    end else begin
      pin_d_r <= pin_s;
    end
  end

  assign pin_low   = ~pin_s;
  assign fall_edge = pin_d_r & pin_low;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire isc_sel;
  wire bfc_sel;
  wire pin_sel;
  wire wr_isc;
  wire wr_bfc;
  wire rd_isc;
  wire rd_bfc;
  wire rd_pin;

  assign isc_sel = (addr == `EIL_ADDR_ISC);
  assign bfc_sel = (addr == `EIL_ADDR_BFC);
  assign pin_sel = (addr == `EIL_ADDR_PIN);
  assign wr_isc  = wr_stb & isc_sel;
  assign wr_bfc  = wr_stb & bfc_sel;
  assign rd_isc  = rd_stb & isc_sel;
  assign rd_bfc  = rd_stb & bfc_sel;
  assign rd_pin  = rd_stb & pin_sel;

  // ----------------------------------------------------------------
  // Sensitivity select
  // ----------------------------------------------------------------
  reg mode_r;
  reg mode_nxt;

  always @* begin
    mode_nxt = mode_r;
    if (wr_isc) begin
      mode_nxt = wdata[`EIL_BIT_MODE];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= `EIL_RST_BIT;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Request mask
  // ----------------------------------------------------------------
  reg request_mask_bit_r;
  reg request_mask_bit_nxt;

  always @* begin
    request_mask_bit_nxt = request_mask_bit_r;
    if (wr_isc) begin
      request_mask_bit_nxt = wdata[`EIL_BIT_MASK];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      request_mask_bit_r <= `EIL_RST_BIT;
    end else begin
      request_mask_bit_r <= request_mask_bit_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Break clear enable
  // ----------------------------------------------------------------
  reg break_clear_enable_r;
  reg break_clear_enable_nxt;

  always @* begin
    break_clear_enable_nxt = break_clear_enable_r;
    if (wr_bfc) begin
      break_clear_enable_nxt = wdata[`EIL_BIT_BRKCLR];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      break_clear_enable_r <= `EIL_RST_BIT;
    end else begin
      break_clear_enable_r <= break_clear_enable_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge sources
  // ----------------------------------------------------------------
  wire ack_bit;
  wire brk_allow;
  wire sw_ack;
  wire ack;

  assign ack_bit   = wdata[`EIL_BIT_ACK];
  // Mode and mask are still written during break; only the ack is
  // held back, so a debugger cannot lose a request by accident
  assign brk_allow = ~break_state | break_clear_enable_r;
  assign sw_ack    = wr_isc & ack_bit & brk_allow;
  assign ack       = sw_ack | vector_fetch;

  // ----------------------------------------------------------------
  // Interrupt latch
  // ----------------------------------------------------------------
  reg latch_r;
  reg latch_nxt;

  // An edge in the same cycle as an ack wins, so it is never lost
  always @* begin
    latch_nxt = latch_r;
    if (ack) begin
      latch_nxt = `EIL_LATCH_CLR;
    end
    if (fall_edge) begin
      latch_nxt = `EIL_LATCH_SET;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= `EIL_RST_BIT;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pending request
  // ----------------------------------------------------------------
  wire level_hold;
  wire pend_nxt;
  wire req_nxt;

  // The low level is kept apart from the latch: an ack clears the latch
  // at once, the level keeps the request up while the pin is low, and
  // so ack and pin release may come in either order
  assign level_hold = mode_nxt & pin_low;
  assign pend_nxt   = latch_nxt | level_hold;
  // The new mask takes effect on the same edge as the write
  assign req_nxt    = pend_nxt & ~request_mask_bit_nxt;

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  reg [7:0] isc_view;
  reg [7:0] bfc_view;
  reg [7:0] pin_view;
  reg [7:0] rdata_nxt;

  // The ack bit is never stored, so it always reads as zero
  always @* begin
    isc_view                = `EIL_RD_ZERO;
    isc_view[`EIL_BIT_MODE] = mode_r;
    isc_view[`EIL_BIT_MASK] = request_mask_bit_r;
    isc_view[`EIL_BIT_PEND] = pending_flag;
  end

  always @* begin
    bfc_view                  = `EIL_RD_ZERO;
    bfc_view[`EIL_BIT_BRKCLR] = break_clear_enable_r;
  end

  always @* begin
    pin_view                  = `EIL_RD_ZERO;
    pin_view[`EIL_BIT_PINLVL] = pin_s;
  end

  // Data stand only in the cycle after the strobe; zero otherwise
  always @* begin
    rdata_nxt = `EIL_RD_ZERO;
    case ({rd_pin, rd_bfc, rd_isc})
      3'h1: begin
        rdata_nxt = isc_view;
      end
      3'h2: begin
        rdata_nxt = bfc_view;
      end
      3'h4: begin
        rdata_nxt = pin_view;
      end
      default: begin
        rdata_nxt = `EIL_RD_ZERO;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `EIL_RD_ZERO;
    end else begin
      rdata <= rdata_nxt;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= `EIL_RST_BIT;
    end else begin
      irq_req <= req_nxt;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_flag <= `EIL_RST_BIT;
    end else begin
      pending_flag <= pend_nxt;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_addr_hi <= `EIL_VEC_HI;
    end else begin
      vector_addr_hi <= `EIL_VEC_HI;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_addr_lo <= `EIL_VEC_LO;
    end else begin
      vector_addr_lo <= `EIL_VEC_LO;
    end
  end
endmodule

// ==== test/eil_chk.sv ====
`timescale 1ns/10ps
module eil_chk (
  input wire        clk,
  input wire        rst_n,
  input wire        irq_pin_n,
  input wire        vector_fetch,
  input wire        break_state,
  input wire [3:0]  addr,
  input wire [7:0]  wdata,
  input wire        wr_stb,
  input wire        rd_stb,
  input wire [7:0]  rdata,
  input wire        irq_req,
  input wire        pending_flag,
  input wire [15:0] vector_addr_hi,
  input wire [15:0] vector_addr_lo
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Eight quiet cycles so no edge is still in the synchroniser
  sequence hi8; irq_pin_n [*8]; endsequence
  sequence fall; irq_pin_n ##1 !irq_pin_n [*4]; endsequence
  sequence ack; wr_stb && addr == 4'h0 && wdata[2] && !break_state; endsequence
  vec_fixed_a: assert property (vector_addr_hi == 16'hFFFA && vector_addr_lo == 16'hFFFB)
    else $error("vector moved");
  rd_idle_a: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("rdata not idle");
  ack_rd_a: assert property (rd_stb && addr == 4'h0 |=> !rdata[2])
    else $error("ack bit read one");
  ack_clr_a: assert property (hi8 ##0 ack |=> !pending_flag)
    else $error("ack did not clear");
  vf_clr_a: assert property (hi8 ##0 vector_fetch |=> !pending_flag)
    else $error("fetch did not clear");
  edge_set_a: assert property (fall |=> pending_flag)
    else $error("fall not latched");
  rise_cause_a: assert property ($rose(pending_flag) |->
    !$past(irq_pin_n, 2) || !$past(irq_pin_n, 3) || !$past(irq_pin_n, 4))
    else $error("flag without pin");
  req_pend_a: assert property (irq_req |-> pending_flag)
    else $error("request without latch");
endmodule
bind eil_top eil_chk i_chk (.clk(clk), .rst_n(rst_n), .irq_pin_n(irq_pin_n),
  .vector_fetch(vector_fetch), .break_state(break_state), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .irq_req(irq_req), .pending_flag(pending_flag),
  .vector_addr_hi(vector_addr_hi), .vector_addr_lo(vector_addr_lo));

// ==== test/eil_src.sv ====
`timescale 1ns/10ps
// Pin source; pin_n starts high and keeps its last driven value while idle
module eil_src (
  input  wire  clk,
  output logic pin_n
);
  initial pin_n = 1'h1;
  task drv(input logic v, input int n);
    @(posedge clk);
    pin_n <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule

// ==== test/tb_eil_top.sv ====
`timescale 1ns/10ps
`include "eil_map.vh"
module tb_eil_top;
  logic       clk = 1'h0;
  logic       rst_n = 1'h0;
  logic       vf = 1'h0;
  logic       brk = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_stb = 1'b0;
  logic       rd_stb = 1'b0;
  wire        pin_n;
  wire  [7:0] rdata;
  wire        req;
  wire        pend;
  wire [15:0] vhi;
  wire [15:0] vlo;
  int         fail_count = 0;
  int         comparisons = 0;
  always #5 clk = ~clk;
  eil_src i_src (.clk(clk), .pin_n(pin_n));
  eil_top i_dut (.clk(clk), .rst_n(rst_n), .irq_pin_n(pin_n), .vector_fetch(vf),
    .break_state(brk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .irq_req(req), .pending_flag(pend),
    .vector_addr_hi(vhi), .vector_addr_lo(vlo));
  task ck(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
    @(negedge clk);
    ck("rdata", {8'h00, rdata}, {8'h00, e});
  endtask
  task pf(input logic p, input logic q);
    @(negedge clk);
    ck("pend", {15'h0000, pend}, {15'h0000, p});
    ck("req", {15'h0000, req}, {15'h0000, q});
  endtask
  task summarize;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    fail_count++;
    summarize;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    rd(`EIL_ADDR_ISC, 8'h00);
    rd(`EIL_ADDR_BFC, 8'h00);
    rd(4'hF, 8'h00);
    rd(`EIL_ADDR_PIN, 8'h01);
    ck("vhi", vhi, `EIL_VEC_HI);
    ck("vlo", vlo, `EIL_VEC_LO);
    i_src.drv(1'h0, 6);
    i_src.drv(1'h1, 8);
    pf(1'h1, 1'h1);
    rd(`EIL_ADDR_ISC, 8'h08);
    wr(`EIL_ADDR_ISC, 8'h02);
    pf(1'h1, 1'h0);
    rd(`EIL_ADDR_ISC, 8'h0A);
    wr(`EIL_ADDR_ISC, 8'h04);
    pf(1'h0, 1'h0);
    i_src.drv(1'h0, 6);
    i_src.drv(1'h1, 8);
    pf(1'h1, 1'h1);
    @(posedge clk);
    vf <= 1'h1;
    @(posedge clk);
    vf <= 1'h0;
    pf(1'h0, 1'h0);
    wr(`EIL_ADDR_ISC, 8'h03);
    i_src.drv(1'h0, 6);
    wr(`EIL_ADDR_ISC, 8'h07);
    pf(1'h1, 1'h0);
    rd(`EIL_ADDR_ISC, 8'h0B);
    i_src.drv(1'h1, 8);
    pf(1'h0, 1'h0);
    i_src.drv(1'h0, 6);
    i_src.drv(1'h1, 8);
    pf(1'h1, 1'h0);
    wr(`EIL_ADDR_ISC, 8'h07);
    pf(1'h0, 1'h0);
    wr(`EIL_ADDR_ISC, 8'h00);
    i_src.drv(1'h0, 6);
    i_src.drv(1'h1, 8);
    brk <= 1'h1;
    wr(`EIL_ADDR_ISC, 8'h04);
    pf(1'h1, 1'h1);
    wr(`EIL_ADDR_BFC, 8'h80);
    rd(`EIL_ADDR_BFC, 8'h80);
    wr(`EIL_ADDR_ISC, 8'h04);
    pf(1'h0, 1'h0);
    @(posedge clk);
    brk <= 1'h0;
    pf(1'h0, 1'h0);
    wr(`EIL_ADDR_ISC, 8'h01);
    i_src.drv(1'h0, 6);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk);
    pf(1'h0, 1'h0);
    rd(`EIL_ADDR_ISC, 8'h00);
    summarize;
  end
endmodule
